/* File: src/nirq_pkg.sv */
/*
  Constants for the interrupt priority and pending block: register offsets,
  field positions, widths and reset values.
  Assumes a 12-bit byte address relative to the controller's base.
*/
package nirq_pkg;
  // ==========================================================================
  // Sizes
  localparam int          NUM_IRQ      = 35;
  localparam int          NUM_PRIO_WRD = 9;
  localparam int          ADDR_W       = 12;
  localparam int          IRQ_NUM_W    = 6;
  localparam int          PRIO_W       = 4;
  localparam int          PRIO_LSB     = 4;
  // Lanes shown as reserved in the priority words have no storage.
  localparam logic [34:0] IRQ_IMPL     = 35'h7_FFFC_FF7F;
  // ==========================================================================
  // Offsets
  localparam logic [11:0] SET_EN_OFS   = 12'h100;
  localparam logic [11:0] CLR_EN_OFS   = 12'h180;
  localparam logic [11:0] SET_PND_OFS  = 12'h200;
  localparam logic [11:0] CLR_PND_OFS  = 12'h280;
  localparam logic [11:0] ACTIVE_OFS   = 12'h300;
  localparam logic [11:0] PRIO_OFS     = 12'h400;
  localparam logic [11:0] PRIO_LAST    = 12'h420;
  localparam logic [11:0] SYS_CTRL_OFS = 12'hD10;
  localparam logic [11:0] SW_TRIG_OFS  = 12'hF00;
  // ==========================================================================
  // Fields and reset values
  localparam int          UNPRIV_BIT   = 4;
  localparam int          TRIG_NUM_W   = 9;
  localparam logic [8:0]  TRIG_NUM_MAX = 9'h0EF;
  localparam logic [3:0]  PRIO_RST     = 4'h0;
  localparam logic [34:0] VEC_RST      = 35'h0_0000_0000;
  localparam logic [31:0] WORD_RST     = 32'h0000_0000;
endpackage

/* File: src/nested_irq_priority_and_pending.sv */
/*
  Priority, enable, pending and active state of the nested interrupt
  controller, with the software trigger and the global mask.
  Assumes a plain register port (read data one cycle after the read strobe),
  request lines synchronous to clock, and a core that reports handler entry
  and return with one-cycle pulses.
*/
// The address-and-strobe port and the register offsets are this design's own decisions.
// Functional notes
// - Each interrupt keeps a priority 0 to 15; lower value is more urgent. Interrupts 7, 16 and 17 have no priority storage and stay at 0.
// - Only bits 7:4 of a priority byte are stored; 3:0 read zero.
// - Priority registers take single-byte writes without touching other lanes.
// - Interrupt N sits in priority word N/4, byte lane N mod 4.
// - Trigger register write makes pending the numbered interrupt, 0 to 239.
// - Unprivileged trigger writes work only while the allow bit is one.
// - Only privileged writes may change the unprivileged trigger allow bit.
// - Handler entry clears pending and sets active.
// - Level interrupt return samples request; high repends, low goes inactive.
// - A high request while not active makes the interrupt pending.
// - A rising edge on the request line latches pending.
// - Set-pending bits or trigger register writes make an interrupt pending.
// - Without a pulse during the handler, return makes the interrupt inactive.
// - Clear-pending on a held level request changes nothing; else clears.
// - A disabled interrupt can still become pending.
// - A global mask set and cleared by the core blocks taking interrupts.
// - Only enabled pending interrupts are taken, chosen by priority.
// - Set and clear enable writes act per bit and read back enables.
// - Clear-pending writes never alter the active state.
// - Active flag reads one while active, also when active and pending.
`timescale 1ns/1ns
`default_nettype none
module nested_irq_priority_and_pending (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [11:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic [3:0]  bus_byte_en,
  input  wire logic        bus_write,
  input  wire logic        bus_read,
  input  wire logic        bus_priv,
  output logic      [31:0] bus_rdata,
  input  wire logic [34:0] irq_req,
  input  wire logic [34:0] irq_level_sens,
  input  wire logic        global_mask_set,
  input  wire logic        global_mask_clear,
  input  wire logic        core_enter,
  input  wire logic [5:0]  core_enter_num,
  input  wire logic        core_return,
  input  wire logic [5:0]  core_return_num,
  output logic             global_mask,
  output logic             take_valid,
  output logic      [5:0]  take_num,
  output logic      [3:0]  take_prio
);
  // ==========================================================================
  // State
  logic [34:0] enable_reg;
  logic [34:0] pending_reg;
  logic [34:0] active_reg;
  logic [34:0] req_prev_reg;
  logic        unpriv_allow_reg;
  logic [3:0]  prio_reg [0:34];
  logic [7:0]  prio_byte [0:35];

  // ==========================================================================
  // Bus decode
  // Unprivileged software reaches nothing but the trigger register.
  logic        wr_priv;
  logic        trig_ok;
  logic [31:0] be_mask;
  logic [31:0] wdata_m;
  logic [63:0] wide_wr;
  logic [34:0] set_en_v;
  logic [34:0] clr_en_v;
  logic [34:0] set_pnd_v;
  logic [34:0] clr_pnd_v;
  logic [34:0] trig_v;
  logic [34:0] enter_v;
  logic [34:0] return_v;
  logic [8:0]  trig_num;

  assign wr_priv  = bus_write & bus_priv;
  assign be_mask  = {{8{bus_byte_en[3]}}, {8{bus_byte_en[2]}},
                     {8{bus_byte_en[1]}}, {8{bus_byte_en[0]}}};
  assign wdata_m  = bus_wdata & be_mask;
  assign wide_wr  = bus_addr[2] ? {wdata_m, 32'h0000_0000} : {32'h0000_0000, wdata_m};
  assign set_en_v  = (wr_priv && bus_addr[11:3] == nirq_pkg::SET_EN_OFS[11:3])
                     ? wide_wr[34:0] : nirq_pkg::VEC_RST;
  assign clr_en_v  = (wr_priv && bus_addr[11:3] == nirq_pkg::CLR_EN_OFS[11:3])
                     ? wide_wr[34:0] : nirq_pkg::VEC_RST;
  assign set_pnd_v = (wr_priv && bus_addr[11:3] == nirq_pkg::SET_PND_OFS[11:3])
                     ? wide_wr[34:0] : nirq_pkg::VEC_RST;
  assign clr_pnd_v = (wr_priv && bus_addr[11:3] == nirq_pkg::CLR_PND_OFS[11:3])
                     ? wide_wr[34:0] : nirq_pkg::VEC_RST;
  assign trig_ok  = bus_write && bus_addr == nirq_pkg::SW_TRIG_OFS &&
                    (bus_priv || unpriv_allow_reg);
  assign trig_num = wdata_m[nirq_pkg::TRIG_NUM_W-1:0];
  assign enter_v  = core_enter ? (35'h1 << core_enter_num) : nirq_pkg::VEC_RST;
  assign return_v = core_return ? (35'h1 << core_return_num) : nirq_pkg::VEC_RST;

  // trigger number decode.
  // Numbers up to 239 are accepted; those without an interrupt do nothing.
  always_comb begin
    trig_v = nirq_pkg::VEC_RST;
    if (trig_ok && trig_num <= nirq_pkg::TRIG_NUM_MAX &&
        trig_num < 9'(nirq_pkg::NUM_IRQ)) begin
      trig_v = 35'h1 << trig_num;
    end
  end

  // ==========================================================================
  // Control word
  // privileged-only allow bit.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      unpriv_allow_reg <= 1'b0;
    end else if (wr_priv && bus_addr == nirq_pkg::SYS_CTRL_OFS && bus_byte_en[0]) begin
      unpriv_allow_reg <= bus_wdata[nirq_pkg::UNPRIV_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      global_mask <= 1'b0;
    end else if (global_mask_set) begin
      global_mask <= 1'b1;
    end else if (global_mask_clear) begin
      global_mask <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_prev_reg <= nirq_pkg::VEC_RST;
    end else begin
      req_prev_reg <= irq_req;
    end
  end

  // ==========================================================================
  // Per-interrupt state
  genvar gi;
  generate
    for (gi = 0; gi < nirq_pkg::NUM_IRQ; gi++) begin : g_irq
      localparam int          LANE = gi % 4;
      localparam logic [11:0] WADR = nirq_pkg::PRIO_OFS + 12'(4 * (gi / 4));
      logic set_ev;
      logic clr_ok;

      // level seen while not active, held off during entry.
      // enable plays no part in going pending.
      assign set_ev = (irq_req[gi] & ~active_reg[gi] & ~enter_v[gi]) |
                      (irq_req[gi] & ~req_prev_reg[gi]) |
                      set_pnd_v[gi] | trig_v[gi] |
                      (return_v[gi] & irq_level_sens[gi] & irq_req[gi]);
      // held level request keeps its pending state.
      assign clr_ok = clr_pnd_v[gi] & ~(irq_level_sens[gi] & irq_req[gi]);

      // level return resamples the request.
      // A new event in the same cycle as a clear wins over it.
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pending_reg[gi] <= 1'b0;
        end else if (set_ev) begin
          pending_reg[gi] <= 1'b1;
        end else if (clr_ok || enter_v[gi]) begin
          pending_reg[gi] <= 1'b0;
        end
      end

      // return without a pulse ends in inactive.
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          active_reg[gi] <= 1'b0;
        end else if (enter_v[gi]) begin
          active_reg[gi] <= 1'b1;
        end else if (return_v[gi]) begin
          active_reg[gi] <= 1'b0;
        end
      end

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          enable_reg[gi] <= 1'b0;
        end else if (set_en_v[gi]) begin
          enable_reg[gi] <= 1'b1;
        end else if (clr_en_v[gi]) begin
          enable_reg[gi] <= 1'b0;
        end
      end

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          prio_reg[gi] <= nirq_pkg::PRIO_RST;
        end else if (wr_priv && bus_addr == WADR && bus_byte_en[LANE] &&
                     nirq_pkg::IRQ_IMPL[gi]) begin
          prio_reg[gi] <= bus_wdata[8*LANE+nirq_pkg::PRIO_LSB +: nirq_pkg::PRIO_W];
        end
      end

      assign prio_byte[gi] = nirq_pkg::IRQ_IMPL[gi] ? {prio_reg[gi], 4'h0} : 8'h00;
    end
  endgenerate
  assign prio_byte[35] = 8'h00;

  // ==========================================================================
  // Selection
  // enabled pending candidates only.
  // strict compare keeps the lowest number on ties.
  logic [34:0] cand;
  logic        best_found;
  logic [5:0]  best_num;
  logic [3:0]  best_prio;

  assign cand = pending_reg & enable_reg & ~active_reg;

  always_comb begin
    best_found = 1'b0;
    best_num   = 6'h00;
    best_prio  = 4'hF;
    for (int i = 0; i < nirq_pkg::NUM_IRQ; i++) begin
      if (cand[i] && (!best_found || prio_reg[i] < best_prio)) begin
        best_found = 1'b1;
        best_num   = 6'(i);
        best_prio  = prio_reg[i];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      take_valid <= 1'b0;
      take_num   <= 6'h00;
      take_prio  <= 4'h0;
    end else begin
      take_valid <= best_found & ~global_mask;
      take_num   <= best_num;
      take_prio  <= best_prio;
    end
  end

  // ==========================================================================
  // Read path
  // The trigger register is write-only and reads zero, as do unmapped words.
  logic [31:0] rd_next;
  logic [63:0] rd_en;
  logic [63:0] rd_pnd;
  logic [63:0] rd_act;
  logic [3:0]  pw;

  assign rd_en  = {29'h0, enable_reg};
  assign rd_pnd = {29'h0, pending_reg};
  assign rd_act = {29'h0, active_reg};
  assign pw     = 4'((bus_addr - nirq_pkg::PRIO_OFS) >> 2);

  always_comb begin
    rd_next = nirq_pkg::WORD_RST;
    if (bus_read && bus_priv) begin
      // both enable words read the enable state.
      if (bus_addr[11:3] == nirq_pkg::SET_EN_OFS[11:3] ||
          bus_addr[11:3] == nirq_pkg::CLR_EN_OFS[11:3]) begin
        rd_next = bus_addr[2] ? rd_en[63:32] : rd_en[31:0];
      end else if (bus_addr[11:3] == nirq_pkg::SET_PND_OFS[11:3] ||
                   bus_addr[11:3] == nirq_pkg::CLR_PND_OFS[11:3]) begin
        rd_next = bus_addr[2] ? rd_pnd[63:32] : rd_pnd[31:0];
      end else if (bus_addr[11:3] == nirq_pkg::ACTIVE_OFS[11:3]) begin
        rd_next = bus_addr[2] ? rd_act[63:32] : rd_act[31:0];
      end else if (bus_addr >= nirq_pkg::PRIO_OFS && bus_addr <= nirq_pkg::PRIO_LAST) begin
        rd_next = {prio_byte[4*pw+3], prio_byte[4*pw+2],
                   prio_byte[4*pw+1], prio_byte[4*pw]};
      end else if (bus_addr == nirq_pkg::SYS_CTRL_OFS) begin
        rd_next = 32'(unpriv_allow_reg) << nirq_pkg::UNPRIV_BIT;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_rdata <= nirq_pkg::WORD_RST;
    end else begin
      bus_rdata <= rd_next;
    end
  end

  // ==========================================================================
  // Checks
  a_prio_low_zero: assert property (@(posedge clock) disable iff (rst)
    bus_read && bus_priv && bus_addr == nirq_pkg::PRIO_OFS
    |=> bus_rdata[3:0] == 4'h0 && bus_rdata[11:8] == 4'h0 && bus_rdata[27:24] == 4'h0)
    else $error("priority low nibble not zero");
  a_byte_lane_keep: assert property (@(posedge clock) disable iff (rst)
    wr_priv && bus_addr == nirq_pkg::PRIO_OFS && bus_byte_en == 4'h2
    |=> $stable(prio_reg[0]) && prio_reg[1] == $past(bus_wdata[15:12]))
    else $error("byte write disturbed neighbour lane");
  a_software_irq_trigger_sets: assert property (@(posedge clock) disable iff (rst)
    trig_ok && bus_byte_en == 4'hF && bus_wdata[8:0] == 9'h008 && !enter_v[8]
    |=> pending_reg[8])
    else $error("trigger write did not set pending");
  a_unpriv_allow_hold: assert property (@(posedge clock) disable iff (rst)
    bus_write && !bus_priv && bus_addr == nirq_pkg::SYS_CTRL_OFS |=> $stable(unpriv_allow_reg))
    else $error("unprivileged write changed allow bit");
  a_entry_state: assert property (@(posedge clock) disable iff (rst)
    core_enter && core_enter_num == 6'h03 ##1 !irq_req[3] && !$past(irq_req[3])
    |-> active_reg[3] && !pending_reg[3])
    else $error("entry did not make interrupt active");
  a_level_rearm: assert property (@(posedge clock) disable iff (rst)
    core_return && core_return_num == 6'h04 && irq_level_sens[4] && irq_req[4]
    |=> pending_reg[4] && !active_reg[4])
    else $error("level interrupt not repended on return");
  a_edge_latch: assert property (@(posedge clock) disable iff (rst)
    irq_req[3] && !req_prev_reg[3] |=> pending_reg[3])
    else $error("rising edge not latched");
  a_clear_hold: assert property (@(posedge clock) disable iff (rst)
    clr_pnd_v[4] && irq_level_sens[4] && irq_req[4] && !enter_v[4]
    |=> pending_reg[4] == $past(pending_reg[4]) || pending_reg[4])
    else $error("clear changed held level interrupt");
  a_take_enabled: assert property (@(posedge clock) disable iff (rst)
    take_valid |-> $past(best_found) && !$past(global_mask) && $past(enable_reg) != 35'h0)
    else $error("take without enabled candidate");
  a_mask_blocks: assert property (@(posedge clock) disable iff (rst)
    global_mask |=> !take_valid)
    else $error("take while globally masked");
  a_rdata_idle: assert property (@(posedge clock) disable iff (rst)
    !bus_read |=> bus_rdata == 32'h0000_0000)
    else $error("read data outside read answer cycle");

  c_take: cover property (@(posedge clock) disable iff (rst) take_valid);
  c_trig: cover property (@(posedge clock) disable iff (rst) trig_ok && !bus_priv);
  c_rearm: cover property (@(posedge clock) disable iff (rst)
    core_return && irq_level_sens[4] && irq_req[4] && core_return_num == 6'h04);
endmodule
`default_nettype wire

/* File: verif/nirq_periph_model.sv */
/*
  Behavioural peripheral side of the controller: drives the request lines.
  Assumes the bench pulses start and service for one clock cycle each.
*/
`timescale 1ns/1ns
`default_nettype none
module nirq_periph_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [34:0] level_sens,
  input  wire logic [34:0] start,
  input  wire logic [34:0] service,
  output logic      [34:0] irq_req
);
  // ==========================================================================
  // Request lines
  // level held until serviced.
  // A pulsed source drops after one cycle, so the controller must latch it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_req <= 35'h0_0000_0000;
    end else begin
      irq_req <= (irq_req & level_sens & ~service) | start;
    end
  end
endmodule
`default_nettype wire

/* File: verif/nested_irq_priority_and_pending_tb_top.sv */
/*
  Self-checking bench for the interrupt priority and pending block.
  Assumes the design package and the peripheral model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module nested_irq_priority_and_pending_tb_top;
  // ==========================================================================
  // Signals
  logic        clock;
  logic        rst;
  logic [11:0] bus_addr;
  logic [31:0] bus_wdata;
  logic [3:0]  bus_byte_en;
  logic        bus_write;
  logic        bus_read;
  logic        bus_priv;
  logic [31:0] bus_rdata;
  logic [34:0] irq_req;
  logic [34:0] irq_level_sens;
  logic [34:0] start;
  logic [34:0] service;
  logic [3:0]  core_ctl;
  logic [5:0]  core_num;
  logic        global_mask;
  logic        take_valid;
  logic [5:0]  take_num;
  logic [3:0]  take_prio;
  int          fail_count;
  int          check_count;

  nested_irq_priority_and_pending uut (
    .clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_byte_en(bus_byte_en), .bus_write(bus_write), .bus_read(bus_read),
    .bus_priv(bus_priv), .bus_rdata(bus_rdata), .irq_req(irq_req),
    .irq_level_sens(irq_level_sens), .global_mask_set(core_ctl[2]),
    .global_mask_clear(core_ctl[3]), .core_enter(core_ctl[0]), .core_enter_num(core_num),
    .core_return(core_ctl[1]), .core_return_num(core_num), .global_mask(global_mask),
    .take_valid(take_valid), .take_num(take_num), .take_prio(take_prio)
  );
  nirq_periph_model periph (
    .clock(clock), .rst(rst), .level_sens(irq_level_sens), .start(start),
    .service(service), .irq_req(irq_req)
  );

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrb(input logic [11:0] a, input logic [31:0] d, input logic p,
                     input logic [3:0] be);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_priv <= p;
    bus_byte_en <= be;
    bus_write <= 1'b1;
    @(posedge clock);
    bus_write <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic p);
    wrb(a, d, p, 4'hF);
  endtask
  task automatic rdc(input logic [11:0] a, input logic p, input logic [31:0] exp);
    @(posedge clock);
    bus_addr <= a;
    bus_priv <= p;
    bus_read <= 1'b1;
    @(posedge clock);
    bus_read <= 1'b0;
    @(negedge clock);
    chk(bus_rdata, exp);
  endtask
  // Kind bits: 0 enter, 1 return, 2 mask set, 3 mask clear.
  task automatic core(input logic [3:0] k, input logic [5:0] n);
    @(posedge clock);
    core_ctl <= k;
    core_num <= n;
    @(posedge clock);
    core_ctl <= 4'h0;
  endtask
  // The extra edge lets the request reach the controller before returning.
  task automatic per(input logic [34:0] s, input logic [34:0] v);
    @(posedge clock);
    start <= s;
    service <= v;
    @(posedge clock);
    start <= 35'h0_0000_0000;
    service <= 35'h0_0000_0000;
    @(posedge clock);
  endtask
  task automatic tkp(input logic v, input logic [5:0] n, input logic [3:0] p);
    repeat (2) @(negedge clock);
    if (v) begin
      chk({21'h0, take_valid, take_num, take_prio}, {21'h0, 1'b1, n, p});
    end else begin
      chk({31'h0, take_valid}, 32'h0000_0000);
    end
  endtask
  task automatic tk(input logic v, input logic [5:0] n);
    tkp(v, n, 4'hF);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    repeat (4000) @(posedge clock);
    fail_count++;
    end_sim();
  end

  // ==========================================================================
  // Tests
  initial begin
    logic [31:0] e;
    fail_count = 0;
    check_count = 0;
    {bus_addr, bus_wdata, bus_write, bus_read, bus_priv} = '0;
    bus_byte_en = 4'hF;
    {start, service, core_ctl, core_num} = '0;
    irq_level_sens = 35'h0_0000_0010;
    rst = 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rdc(nirq_pkg::PRIO_OFS, 1'b1, nirq_pkg::WORD_RST);
    rdc(nirq_pkg::SYS_CTRL_OFS, 1'b1, nirq_pkg::WORD_RST);
    for (int w = 0; w < nirq_pkg::NUM_PRIO_WRD; w++) begin
      wr(nirq_pkg::PRIO_OFS + 12'(4 * w), 32'hFFFF_FFFF, 1'b1);
      for (int l = 0; l < 4; l++) begin
        e[8*l+:8] = ((4*w+l) < nirq_pkg::NUM_IRQ && nirq_pkg::IRQ_IMPL[4*w+l]) ? 8'hF0 : 8'h00;
      end
      rdc(nirq_pkg::PRIO_OFS + 12'(4 * w), 1'b1, e);
    end
    wrb(nirq_pkg::PRIO_OFS, 32'h0000_3A00, 1'b1, 4'h2);
    rdc(nirq_pkg::PRIO_OFS, 1'b1, 32'hF0F0_30F0);
    rdc(nirq_pkg::PRIO_OFS, 1'b0, 32'h0000_0000);
    wr(nirq_pkg::SET_EN_OFS, 32'h0000_010A, 1'b1);
    wr(nirq_pkg::CLR_EN_OFS, 32'h0000_0002, 1'b1);
    rdc(nirq_pkg::CLR_EN_OFS, 1'b1, 32'h0000_0108);
    wr(nirq_pkg::SW_TRIG_OFS, 32'h0000_0001, 1'b1);
    wr(nirq_pkg::SW_TRIG_OFS, 32'h0000_00EF, 1'b1);
    rdc(nirq_pkg::SET_PND_OFS, 1'b1, 32'h0000_0002);
    tk(1'b0, 6'h00);
    wr(nirq_pkg::SW_TRIG_OFS, 32'h0000_0008, 1'b0);
    wr(nirq_pkg::SYS_CTRL_OFS, 32'h0000_0010, 1'b0);
    wr(nirq_pkg::SW_TRIG_OFS, 32'h0000_0008, 1'b0);
    rdc(nirq_pkg::SET_PND_OFS, 1'b1, 32'h0000_0002);
    wr(nirq_pkg::SYS_CTRL_OFS, 32'h0000_0010, 1'b1);
    wr(nirq_pkg::SW_TRIG_OFS, 32'h0000_0008, 1'b0);
    rdc(nirq_pkg::SET_PND_OFS, 1'b1, 32'h0000_0102);
    tk(1'b1, 6'h08);
    per(35'h0_0000_0008, 35'h0_0000_0000);
    tk(1'b1, 6'h03);
    core(4'h4, 6'h00);
    tk(1'b0, 6'h00);
    core(4'h8, 6'h00);
    tk(1'b1, 6'h03);
    core(4'h1, 6'h03);
    rdc(nirq_pkg::SET_PND_OFS, 1'b1, 32'h0000_0102);
    tk(1'b1, 6'h08);
    wr(nirq_pkg::SW_TRIG_OFS, 32'h0000_0003, 1'b1);
    rdc(nirq_pkg::ACTIVE_OFS, 1'b1, 32'h0000_0008);
    wr(nirq_pkg::CLR_PND_OFS, 32'h0000_0108, 1'b1);
    rdc(nirq_pkg::ACTIVE_OFS, 1'b1, 32'h0000_0008);
    core(4'h2, 6'h03);
    rdc(nirq_pkg::ACTIVE_OFS, 1'b1, 32'h0000_0000);
    wr(nirq_pkg::SET_EN_OFS, 32'h0000_0010, 1'b1);
    per(35'h0_0000_0010, 35'h0_0000_0000);
    rdc(nirq_pkg::SET_PND_OFS, 1'b1, 32'h0000_0012);
    wr(nirq_pkg::CLR_PND_OFS, 32'h0000_0012, 1'b1);
    rdc(nirq_pkg::SET_PND_OFS, 1'b1, 32'h0000_0010);
    core(4'h1, 6'h04);
    core(4'h2, 6'h04);
    rdc(nirq_pkg::SET_PND_OFS, 1'b1, 32'h0000_0010);
    core(4'h1, 6'h04);
    per(35'h0_0000_0000, 35'h0_0000_0010);
    core(4'h2, 6'h04);
    rdc(nirq_pkg::SET_PND_OFS, 1'b1, 32'h0000_0000);
    rdc(nirq_pkg::ACTIVE_OFS, 1'b1, 32'h0000_0000);
    wrb(nirq_pkg::PRIO_OFS + 12'h008, 32'hAAAA_AA2A, 1'b1, 4'h1);
    rdc(nirq_pkg::PRIO_OFS + 12'h008, 1'b1, 32'hF0F0_F020);
    wr(nirq_pkg::SET_PND_OFS, 32'h0000_0108, 1'b1);
    rdc(nirq_pkg::SET_PND_OFS, 1'b1, 32'h0000_0108);
    tkp(1'b1, 6'h08, 4'h2);
    end_sim();
  end
endmodule
`default_nettype wire
